// ---- src/key_sync.sv ----
// two-flop synchroniser and debouncer for panel keys, sensor and straps
`default_nettype none
module key_sync #(
  parameter int N   = 6,
  parameter int DEB = 1000
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [N-1:0] pinRaw,
  output logic      [N-1:0] level,
  output logic      [N-1:0] rise
);

  localparam int CW = $clog2(DEB + 1);

  // refused at elaboration: a zero width or zero debounce cannot be served
  if (N < 1 || DEB < 1)
  begin : gen_bad_param
    $error("key_sync: N and DEB must be at least 1");
  end

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : gen_bit
      logic          s1_ff;
      logic          s2_ff;
      logic          stable_ff;
      logic          rise_ff;
      logic [CW-1:0] cnt_ff;
      wire           differs = (s2_ff != stable_ff);
      wire           settled = (cnt_ff == CW'(DEB - 1));

      // a level must stay changed for DEB cycles before it is believed
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          s1_ff     <= 1'b0;
          s2_ff     <= 1'b0;
          stable_ff <= 1'b0;
          rise_ff   <= 1'b0;
          cnt_ff    <= '0;
        end
        else
        begin
          s1_ff   <= pinRaw[g];
          s2_ff   <= s1_ff;
          rise_ff <= differs && settled && s2_ff;
          cnt_ff  <= (differs && !settled) ? cnt_ff + CW'(1) : '0;
          if (differs && settled)
            stable_ff <= s2_ff;
        end
      end

      assign level[g] = stable_ff;
      assign rise[g]  = rise_ff;
    end
  endgenerate

endmodule
`default_nettype wire

// ---- src/panel_defs.svh ----
// constants of the printer front-panel controller: offsets, fields, resets, timing
`ifndef PANEL_DEFS_SVH
`define PANEL_DEFS_SVH

`define CLK_PERIOD_NS   5
`define DEBOUNCE_NS     5000
`define DEBOUNCE_CYC    ((`DEBOUNCE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STARTUP_NS      20000
`define STARTUP_CYC     ((`STARTUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define REG_CTRL        12'h000
`define REG_STATUS      12'h004
`define REG_COUNT       12'h008

`define CTRL_SEL_BIT    0
`define CTRL_ADV_BIT    1
`define CTRL_RST        1'b0

`define STS_MODE_LSB    0
`define STS_PAPER_BIT   2
`define STS_BUSY_BIT    3
`define STS_FEED_BIT    4
`define STS_TRACE_BIT   5
`define STS_PAUSED_BIT  6
`define STS_CHIN_BIT    8
`define STS_NDIR_BIT    9
`define STS_BIGF_BIT    10

`define TEST_FIRST_CHAR 8'h20
`define TEST_LAST_CHAR  8'h7e

`endif

// ---- src/panel_pkg.sv ----
// types shared by the printer front-panel controller
`default_nettype none
package panel_pkg;

  typedef enum logic [1:0] {
    MODE_ONLINE   = 2'b00,
    MODE_PAUSING  = 2'b01,
    MODE_OFFLINE  = 2'b10,
    MODE_SELFTEST = 2'b11
  } mode_t;

  typedef struct packed {
    logic red;
    logic green;
  } lamp_t;

  typedef struct packed {
    logic rawTraceMode;
    logic chinese;
    logic normalDir;
    logic bigFont;
  } cfg_t;

  typedef struct packed {
    logic [7:0] data;
    logic       strobe;
  } host_in_t;

  function automatic logic [7:0] hex_ascii(input logic [3:0] nib);
    hex_ascii = (nib < 4'ha) ? (8'h30 + {4'h0, nib}) : (8'h37 + {4'h0, nib});
  endfunction

endpackage
`default_nettype wire

// ---- src/printer_panel_mode_control.sv ----
// front-panel mode controller of the impact panel printer with APB status/control
//
// The address map and register access over APB are this design's own decisions.
`include "panel_defs.svh"
`default_nettype none
// What this block does
// R1 - lamp: red offline no paper, green online and not busy, yellow online not busy no paper, else dark
// R2 - comes up on-line after power-up and after leaving self-test
// R3 - select press when on-line and idle goes off-line, lamp dark (red if paper is out)
// R4 - select press when off-line returns on-line, lamp relit
// R5 - host bytes refused while off-line
// R6 - select during printing finishes current row, then pauses off-line
// R7 - next select press after pause resumes the interrupted job
// R8 - select held at power-up enters raw trace mode, bytes printed in hex
// R9 - off-line, paper feeds exactly while the advance key is held
// R10 - off-line, advance held then select pressed enters self-test
// R11 - self-test prints every valid character code
// R12 - self-test ends by itself after the full listing
// R13 - select during self-test abandons it at once
// R14 - host data moves one byte at a time over eight bits
// R15 - select press stops a key-started paper feed
// R16 - charset strap picks alphanumeric (open) or double-byte (fitted) printing
// R17 - direction strap: fitted normal, open reverse
// R18 - font strap picks 12x12 (default) or 15x16 glyphs
// R19 - busy towards host when off-line, paused, self-test or not ready
// R20 - host presents a byte only when not busy, holds it until acknowledged
module printer_panel_mode_control
  import panel_pkg::*;
#(
  parameter int DEBOUNCE_CYC = `DEBOUNCE_CYC,
  parameter int STARTUP_CYC  = `STARTUP_CYC
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        selectKeyRaw,
  input  wire logic        paperAdvanceKeyRaw,
  input  wire logic        paperOutRaw,
  input  wire logic        charsetStrap,
  input  wire logic        printDirectionStrap,
  input  wire logic        fontSizeStrap,
  input  wire host_in_t    hostIn,
  output logic             hostBusy,
  output logic             hostAck,
  output logic      [7:0]  prnData,
  output logic             prnValid,
  input  wire logic        prnReady,
  input  wire logic        rowDone,
  output logic             paperFeed,
  output lamp_t            lamp,
  output cfg_t             cfg
);

  localparam int SW = $clog2(STARTUP_CYC + 1);

  // refused at elaboration: straps must settle before the window closes
  if (STARTUP_CYC <= DEBOUNCE_CYC + 4)
  begin : gen_bad_startup
    $error("STARTUP_CYC must exceed the debounce time");
  end

  ////////////////////////////////////////////////////////////////////////////
  // input conditioning

  logic [5:0] lvl;
  logic [5:0] rise;

  key_sync #(
    .N   (6),
    .DEB (DEBOUNCE_CYC)
  ) u_keys (
    .clk    (clk),
    .arst_n (arst_n),
    .pinRaw ({fontSizeStrap, printDirectionStrap, charsetStrap,
              paperOutRaw, paperAdvanceKeyRaw, selectKeyRaw}),
    .level  (lvl),
    .rise   (rise)
  );

  // the strobe is not debounced: the host is logic, not a contact
  logic       strobeS1_ff;
  logic       strobeS2_ff;
  logic       strobeS3_ff;
  logic [7:0] dataS1_ff;
  logic [7:0] dataS2_ff;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      strobeS1_ff <= 1'b0;
      strobeS2_ff <= 1'b0;
      strobeS3_ff <= 1'b0;
      dataS1_ff   <= 8'h00;
      dataS2_ff   <= 8'h00;
    end
    else
    begin
      strobeS1_ff <= hostIn.strobe;
      strobeS2_ff <= strobeS1_ff;
      strobeS3_ff <= strobeS2_ff;
      dataS1_ff   <= hostIn.data;
      dataS2_ff   <= dataS1_ff;
    end
  end

  wire strobeRise = strobeS2_ff && !strobeS3_ff;
  wire paperOut   = lvl[2];

  ////////////////////////////////////////////////////////////////////////////
  // power-up window: straps and the held select key are caught at its end

  logic [SW-1:0] startCnt_ff;
  logic          startDone_ff;
  cfg_t          cfg_ff;

  wire startEnd = !startDone_ff && (startCnt_ff == SW'(STARTUP_CYC - 1));

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      startCnt_ff  <= '0;
      startDone_ff <= 1'b0;
      cfg_ff       <= '0;
    end
    else if (startEnd)
    begin
      startDone_ff        <= 1'b1;
      cfg_ff.rawTraceMode <= lvl[0]; // R8
      cfg_ff.chinese      <= lvl[3]; // R16
      cfg_ff.normalDir    <= lvl[4]; // R17
      cfg_ff.bigFont      <= lvl[5]; // R18
    end
    else if (!startDone_ff)
      startCnt_ff <= startCnt_ff + SW'(1);
  end

  assign cfg = cfg_ff;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, read data latched in the setup phase

  logic        ctrlAdv_ff;
  logic        swSel_ff;
  logic [31:0] byteCnt_ff;
  logic [31:0] prdata_ff;

  wire hitCtrl   = (paddr == `REG_CTRL);
  wire hitStatus = (paddr == `REG_STATUS);
  wire hitCount  = (paddr == `REG_COUNT);
  wire hit       = hitCtrl || hitStatus || hitCount;
  wire setup     = psel && !penable;
  wire wrCtrl    = psel && penable && pwrite && hitCtrl;

  mode_t mode_ff;
  mode_t nxt_mode;
  logic  holdValid_ff;
  logic  paused_ff;
  logic  busy;

  wire [31:0] statusWord = {21'h0, cfg_ff.bigFont, cfg_ff.normalDir, cfg_ff.chinese,
                            1'b0, paused_ff, cfg_ff.rawTraceMode, paperFeed, busy,
                            paperOut, mode_ff};
  wire [31:0] readMux = hitCtrl   ? {30'h0, ctrlAdv_ff, 1'b0} :
                        hitStatus ? statusWord :
                        hitCount  ? byteCnt_ff : 32'h0;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrlAdv_ff <= `CTRL_RST;
      swSel_ff   <= 1'b0;
      prdata_ff  <= 32'h0;
    end
    else
    begin
      swSel_ff <= wrCtrl && pwdata[`CTRL_SEL_BIT];
      if (wrCtrl)
        ctrlAdv_ff <= pwdata[`CTRL_ADV_BIT];
      if (setup)
        prdata_ff <= readMux;
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  ////////////////////////////////////////////////////////////////////////////
  // mode state machine

  logic rowBusy_ff;
  logic stValid;
  logic [7:0] stData;
  logic stDone;

  wire selEv   = startDone_ff && (rise[0] || swSel_ff);
  wire advHeld = lvl[1] || ctrlAdv_ff;
  wire toTest  = (mode_ff == MODE_OFFLINE) && selEv && advHeld;
  wire abortSt = (mode_ff == MODE_SELFTEST) && selEv;

  always_comb
  begin
    nxt_mode = mode_ff;
    unique case (mode_ff)
      MODE_ONLINE:
        if (selEv)
          nxt_mode = rowBusy_ff ? MODE_PAUSING : MODE_OFFLINE; // R3 R6
      MODE_PAUSING:
        if (!rowBusy_ff)
          nxt_mode = MODE_OFFLINE; // R6
      MODE_OFFLINE:
        if (toTest)
          nxt_mode = MODE_SELFTEST; // R10
        else if (selEv)
          nxt_mode = MODE_ONLINE; // R4 R7
      MODE_SELFTEST:
        if (selEv || stDone)
          nxt_mode = MODE_ONLINE; // R2 R12 R13
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_ff   <= MODE_ONLINE; // R2
      paused_ff <= 1'b0;
    end
    else
    begin
      mode_ff <= nxt_mode;
      if (mode_ff == MODE_PAUSING && nxt_mode == MODE_OFFLINE)
        paused_ff <= 1'b1;
      else if (nxt_mode != MODE_OFFLINE)
        paused_ff <= 1'b0;
    end
  end

  // feed lasts only while off-line, so the select press that leaves off-line stops it
  assign paperFeed = (mode_ff == MODE_OFFLINE) && advHeld; // R9 R15

  ////////////////////////////////////////////////////////////////////////////
  // host byte intake, one-byte holder and print output stage

  logic [7:0] holdByte_ff;
  logic       hexPhase_ff;
  logic       ack_ff;
  logic [7:0] prnData_ff;
  logic       prnValid_ff;

  assign busy = !startDone_ff || (mode_ff != MODE_ONLINE) || holdValid_ff; // R5 R19

  wire acc      = strobeRise && !busy; // R14 R20
  wire outFree  = !prnValid_ff || prnReady;
  wire sendHold = holdValid_ff && outFree && (mode_ff == MODE_ONLINE);
  wire sendSt   = stValid && outFree && (mode_ff == MODE_SELFTEST);
  wire holdLast = !cfg_ff.rawTraceMode || hexPhase_ff;
  wire [7:0] holdOut = !cfg_ff.rawTraceMode ? holdByte_ff :
                       hexPhase_ff ? hex_ascii(holdByte_ff[3:0]) : hex_ascii(holdByte_ff[7:4]); // R8

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      holdValid_ff <= 1'b0;
      holdByte_ff  <= 8'h00;
      hexPhase_ff  <= 1'b0;
      ack_ff       <= 1'b0;
      byteCnt_ff   <= 32'h0;
    end
    else
    begin
      ack_ff <= acc;
      if (acc)
      begin
        holdValid_ff <= 1'b1;
        holdByte_ff  <= dataS2_ff;
        hexPhase_ff  <= 1'b0;
        byteCnt_ff   <= byteCnt_ff + 32'h1;
      end
      else if (sendHold)
      begin
        holdValid_ff <= !holdLast;
        hexPhase_ff  <= !hexPhase_ff;
      end
    end
  end

  // a paused job keeps its byte in the holder, so resuming loses nothing
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prnData_ff  <= 8'h00;
      prnValid_ff <= 1'b0;
      rowBusy_ff  <= 1'b0;
    end
    else
    begin
      rowBusy_ff <= (rowBusy_ff && !rowDone) || (prnValid_ff && prnReady); // R6
      if (sendSt || sendHold)
      begin
        prnValid_ff <= 1'b1;
        prnData_ff  <= sendSt ? stData : holdOut;
      end
      else if (prnReady)
        prnValid_ff <= 1'b0;
    end
  end

  selftest_gen u_test (
    .clk    (clk),
    .arst_n (arst_n),
    .start  (toTest),
    .abort  (abortSt),
    .ready  (outFree && (mode_ff == MODE_SELFTEST)),
    .valid  (stValid),
    .data   (stData),
    .done   (stDone)
  );

  assign hostBusy = busy;
  assign hostAck  = ack_ff;
  assign prnData  = prnData_ff;
  assign prnValid = prnValid_ff;

  ////////////////////////////////////////////////////////////////////////////
  // status lamp; yellow is red and green together

  wire onlineIdle = (mode_ff == MODE_ONLINE) && !busy;

  assign lamp.red   = ((mode_ff == MODE_OFFLINE) || onlineIdle) && paperOut; // R1
  assign lamp.green = onlineIdle; // R1 R3 R4

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_lamp_colour: assert property (@(posedge clk) disable iff (!arst_n) // R1
    (mode_ff == MODE_OFFLINE) |-> !lamp.green && (lamp.red == paperOut))
    else $error("off-line lamp colour wrong");

  a_offline_refuse: assert property (@(posedge clk) disable iff (!arst_n) // R5
    (mode_ff != MODE_ONLINE) && strobeRise |=> !hostAck && $stable(byteCnt_ff))
    else $error("byte taken while not on-line");

  a_row_pause: assert property (@(posedge clk) disable iff (!arst_n) // R6
    (mode_ff == MODE_ONLINE) && selEv && rowBusy_ff |=> mode_ff == MODE_PAUSING)
    else $error("select during a row did not pause");

  a_select_online: assert property (@(posedge clk) disable iff (!arst_n) // R4
    (mode_ff == MODE_OFFLINE) && selEv && !advHeld |=> mode_ff == MODE_ONLINE)
    else $error("select off-line did not return on-line");

  a_feed_follow: assert property (@(posedge clk) disable iff (!arst_n) // R9
    (mode_ff == MODE_OFFLINE) && $fell(advHeld) |-> !paperFeed)
    else $error("feed outlived the advance key");

  a_test_enter: assert property (@(posedge clk) disable iff (!arst_n) // R10
    toTest |=> mode_ff == MODE_SELFTEST ##1 stValid)
    else $error("self-test not entered");

  a_test_abort: assert property (@(posedge clk) disable iff (!arst_n) // R13
    abortSt |=> mode_ff == MODE_ONLINE && !stValid)
    else $error("self-test not abandoned at once");

  a_byte_ack: assert property (@(posedge clk) disable iff (!arst_n) // R14
    acc |=> hostAck && hostBusy && holdByte_ff == $past(dataS2_ff) ##1 !hostAck)
    else $error("accepted byte not acknowledged");

endmodule
`default_nettype wire

// ---- src/selftest_gen.sv ----
// self-test listing generator: walks the printable character codes once
`include "panel_defs.svh"
`default_nettype none
module selftest_gen #(
  parameter logic [7:0] FIRST = `TEST_FIRST_CHAR,
  parameter logic [7:0] LAST  = `TEST_LAST_CHAR
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic       ready,
  output logic            valid,
  output logic      [7:0] data,
  output logic            done
);

  // refused at elaboration: the walk only counts upwards
  if (FIRST > LAST)
  begin : gen_bad_range
    $error("selftest_gen: FIRST above LAST");
  end

  logic       active_ff;
  logic [7:0] code_ff;
  logic       done_ff;

  wire step = active_ff && ready;
  wire last = (code_ff == LAST);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      active_ff <= 1'b0;
      code_ff   <= FIRST;
      done_ff   <= 1'b0;
    end
    else
    begin
      done_ff <= step && last && !abort;
      if (start)
      begin
        active_ff <= 1'b1;
        code_ff   <= FIRST;
      end
      else if (abort)
        active_ff <= 1'b0; // R13
      else if (step)
      begin
        active_ff <= !last; // R12
        code_ff   <= last ? code_ff : code_ff + 8'h01; // R11
      end
    end
  end

  assign valid = active_ff;
  assign data  = code_ff;
  assign done  = done_ff;

  a_walk_step: assert property (@(posedge clk) disable iff (!arst_n) // R11
    step && !last && !abort && !start |=> valid && data == $past(data) + 8'h01)
    else $error("self-test code did not advance by one");

  a_listing_end: assert property (@(posedge clk) disable iff (!arst_n) // R12
    step && last && !abort && !start |=> done && !valid ##1 !done)
    else $error("self-test did not end after the last code");

endmodule
`default_nettype wire

// ---- test/host_model.sv ----
// host processor model on the parallel data port
`default_nettype none
module host_model
  import panel_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     hostBusy,
  input  wire logic     hostAck,
  output var  host_in_t hostIn
);
  timeunit 1ns;
  timeprecision 1ps;
  initial hostIn = '0;
  // pushy skips the busy wait; only the refusal scenario sets it
  task automatic send(input logic [7:0] b, input logic pushy, output logic acked);
    int n;
    acked = 1'b0;
    n = 0;
    while (!pushy && hostBusy !== 1'b0 && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    hostIn <= '{data: b, strobe: 1'b1};
    for (n = 0; n < 12 && !acked; n++)
    begin
      @(posedge clk);
      acked = (hostAck === 1'b1);
    end
    hostIn.strobe <= 1'b0;
    @(posedge clk);
    // released data lines must not keep looking valid
    hostIn.data <= ~b;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ---- test/tb_printer_panel_mode_control.sv ----
// self-checking bench of the printer front-panel mode controller
`include "panel_defs.svh"
`default_nettype none
module tb_printer_panel_mode_control import panel_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEB = 4;
  localparam int START = 16;
  localparam int KEY = DEB + 8;
  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, lastErr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, s;
  logic        selectKeyRaw, advKey, paperOut, chStrap, dirStrap, fontStrap;
  logic        hostBusy, hostAck, prnValid, prnReady, rowDone, paperFeed, ack;
  logic [7:0]  prnData;
  host_in_t    hostIn;
  lamp_t       lamp;
  cfg_t        cfg;
  logic [7:0]  got[$];
  int          nMismatch, totalChecks, cyc;

  printer_panel_mode_control #(.DEBOUNCE_CYC(DEB), .STARTUP_CYC(START)) i_printer_panel_mode_control (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .selectKeyRaw(selectKeyRaw),
    .paperAdvanceKeyRaw(advKey), .paperOutRaw(paperOut), .charsetStrap(chStrap),
    .printDirectionStrap(dirStrap), .fontSizeStrap(fontStrap), .hostIn(hostIn), .hostBusy(hostBusy),
    .hostAck(hostAck), .prnData(prnData), .prnValid(prnValid), .prnReady(prnReady), .rowDone(rowDone),
    .paperFeed(paperFeed), .lamp(lamp), .cfg(cfg));
  host_model i_host (.clk(clk), .hostBusy(hostBusy), .hostAck(hostAck), .hostIn(hostIn));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
    if (prnValid === 1'b1 && prnReady === 1'b1) got.push_back(prnData);
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      nMismatch++;
      stop_test();
    end
  end
////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    totalChecks++;
    if (g !== e)
    begin
      nMismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // the wait ends when pready is seen high; only the bench timeout ends it otherwise
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    r = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so a following call never re-drives psel in this time step
    @(posedge clk);
  endtask
  task automatic expMode(input logic [1:0] m);
    apb(1'b0, `REG_STATUS, 32'h0, s);
    chk(32'(s[1:0]), 32'(m));
  endtask
  task automatic pressSel();
    selectKeyRaw <= 1'b1;
    hold(KEY);
    selectKeyRaw <= 1'b0;
    hold(KEY);
  endtask
  task automatic rowEnd();
    rowDone <= 1'b1;
    @(posedge clk);
    rowDone <= 1'b0;
    hold(2);
  endtask
////////////////////////////////////////////////////////////////////////////////
  task automatic testPowerUp();
    expMode(2'h0);
    chk(32'(lamp), 32'h1);
    chk(32'(hostBusy), 32'h0);
    chk(32'(cfg), 32'h5);
    chk(32'(s[10:8]), 32'h5);
    $display("test powerup done");
  endtask
  task automatic testHostByte();
    got.delete();
    i_host.send(8'h5a, 1'b0, ack);
    chk(32'(ack), 32'h1);
    hold(10);
    chk(32'(got.size()), 32'h1);
    chk(32'(got[0]), 32'h5a);
    apb(1'b0, `REG_COUNT, 32'h0, s);
    chk(s, 32'h1);
    rowEnd();
    $display("test hostbyte done");
  endtask
  task automatic testOffline();
    pressSel();
    expMode(2'h2);
    chk(32'(lamp), 32'h0);
    chk(32'(hostBusy), 32'h1);
    i_host.send(8'h11, 1'b1, ack);
    chk(32'(ack), 32'h0);
    apb(1'b0, `REG_COUNT, 32'h0, s);
    chk(s, 32'h1);
    paperOut <= 1'b1;
    hold(KEY);
    chk(32'(lamp), 32'h2);
    apb(1'b0, `REG_STATUS, 32'h0, s);
    chk(32'(s[3:2]), 32'h3);
    pressSel();
    expMode(2'h0);
    chk(32'(lamp), 32'h3);
    paperOut <= 1'b0;
    hold(KEY);
    chk(32'(lamp), 32'h1);
    $display("test offline done");
  endtask
  task automatic testRegs();
    apb(1'b1, `REG_CTRL, 32'h2, s);
    apb(1'b0, `REG_CTRL, 32'h0, s);
    chk(s, 32'h2);
    chk(32'(paperFeed), 32'h0);
    apb(1'b1, `REG_CTRL, 32'h3, s);
    hold(3);
    chk(32'(paperFeed), 32'h1);
    expMode(2'h2);
    chk(32'(s[4]), 32'h1);
    apb(1'b1, `REG_CTRL, 32'h0, s);
    hold(2);
    chk(32'(paperFeed), 32'h0);
    apb(1'b1, `REG_CTRL, 32'h1, s);
    hold(2);
    expMode(2'h0);
    apb(1'b0, 12'h0f0, 32'h0, s);
    chk({lastErr, s[30:0]}, 32'h80000000);
    $display("test regs done");
  endtask
  task automatic testSelfTest();
    int n;
    pressSel();
    advKey <= 1'b1;
    hold(KEY);
    chk(32'(paperFeed), 32'h1);
    got.delete();
    selectKeyRaw <= 1'b1;
    hold(KEY);
    chk(32'(paperFeed), 32'h0);
    expMode(2'h3);
    selectKeyRaw <= 1'b0;
    advKey <= 1'b0;
    for (n = 0; n < 1000 && got.size() < 95; n++) @(posedge clk);
    hold(20);
    chk(32'(got.size()), 32'd95);
    for (n = 0; n < 95; n++) chk(32'(got[n]), 32'h20 + 32'(n));
    expMode(2'h0);
    rowEnd();
    $display("test selftest done");
  endtask
  task automatic testAbort();
    pressSel();
    advKey <= 1'b1;
    prnReady <= 1'b0;
    hold(KEY);
    pressSel();
    advKey <= 1'b0;
    expMode(2'h3);
    selectKeyRaw <= 1'b1;
    hold(KEY);
    got.delete();
    prnReady <= 1'b1;
    hold(4);
    expMode(2'h0);
    chk(32'(got.size() > 1), 32'h0);
    selectKeyRaw <= 1'b0;
    hold(KEY);
    rowEnd();
    $display("test abort done");
  endtask
  task automatic testPause();
    i_host.send(8'h41, 1'b0, ack);
    hold(8);
    pressSel();
    expMode(2'h1);
    rowEnd();
    expMode(2'h2);
    chk(32'(s[6]), 32'h1);
    pressSel();
    expMode(2'h0);
    chk(32'(s[6]), 32'h0);
    i_host.send(8'h42, 1'b0, ack);
    chk(32'(ack), 32'h1);
    rowEnd();
    $display("test pause done");
  endtask
  task automatic testTrace();
    arst_n <= 1'b0;
    selectKeyRaw <= 1'b1;
    chStrap <= 1'b0;
    dirStrap <= 1'b1;
    fontStrap <= 1'b0;
    hold(3);
    arst_n <= 1'b1;
    hold(START + 8);
    selectKeyRaw <= 1'b0;
    hold(KEY);
    expMode(2'h0);
    chk(32'(s[5]), 32'h1);
    chk(32'(cfg), 32'ha);
    got.delete();
    i_host.send(8'h3a, 1'b0, ack);
    hold(12);
    chk(32'(got.size()), 32'h2);
    chk({24'h0, got[0]}, 32'h33);
    chk({24'h0, got[1]}, 32'h41);
    $display("test trace done");
  endtask
////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {selectKeyRaw, advKey, paperOut, rowDone, dirStrap} = '0;
    {chStrap, fontStrap, prnReady} = 3'h7;
    hold(6);
    arst_n <= 1'b1;
    hold(START + 8);
    testPowerUp();
    testHostByte();
    testOffline();
    testRegs();
    testSelfTest();
    testAbort();
    testPause();
    testTrace();
    stop_test();
  end
endmodule
`default_nettype wire
